// ==== lfc_led_flash_trigger.sv ====
// Purpose: Fires two calibration LEDs locked to the GPS pulse-per-second or to the FPGA delayed trigger
// Assumes: Settings arrive from an I2C register bank as a write strobe plus values
// Notes:   Fixed pin-to-LED latency; one clock of 4 ns is the timing grain
`timescale 1ns/1ns
`include "lfc_regs.svh"
module lfc_led_flash_trigger
    import lfc_pkg::*;
#(
    parameter int unsigned DAC_BITS       = `LFC_DAC_BITS,
    parameter int unsigned OFFSET_W       = `LFC_OFFSET_W,
    parameter int unsigned OFFSET_MAX_CYC = `LFC_OFFSET_MAX_CYC,
    parameter int unsigned PULSE_CYC      = `LFC_PULSE_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ppsIn,
    input  wire logic                ppsGateArm,
    input  wire logic                fpgaDelayedTrigger,
    input  wire logic                cfgWrite,
    input  wire lfc_mode_e           cfgMode,
    input  wire logic [1:0]          cfgLedMask,
    input  wire logic [OFFSET_W-1:0] cfgOffset,
    input  wire logic [DAC_BITS-1:0] cfgDacCode,
    output logic [1:0]               ledTrigger,
    output logic                     triggerFlag,
    output logic [DAC_BITS-1:0]      dacCode,
    output logic                     dacLoad,
    output logic                     gateArmed,
    output lfc_mode_e                modeActive
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic ppsRise;
    logic armLevel;
    logic armRise;
    logic fpgaRise;

    // Same depth on every path keeps pin-to-LED latency equal
    lfc_sync_edge uPpsSync (
        .clk       (clk),
        .rst_n     (rst_n),
        .asyncIn   (ppsIn),
        .syncLevel (),
        .riseEdge  (ppsRise)
    );

    lfc_sync_edge uArmSync (
        .clk       (clk),
        .rst_n     (rst_n),
        .asyncIn   (ppsGateArm),
        .syncLevel (armLevel),
        .riseEdge  (armRise)
    );

    lfc_sync_edge uFpgaSync (
        .clk       (clk),
        .rst_n     (rst_n),
        .asyncIn   (fpgaDelayedTrigger),
        .syncLevel (),
        .riseEdge  (fpgaRise)
    );

    // ****************************************************************
    // Settings
    // ****************************************************************
    lfc_mode_e             mode_reg;
    logic [1:0]            ledMask_reg;
    logic [OFFSET_W-1:0]   offset_reg;
    logic [DAC_BITS-1:0]   dacCode_reg;
    logic                  dacLoad_reg;
    logic [OFFSET_W-1:0]   offsetClamped;
    logic                  offsetTooBig;

    // Offsets past 1 ms are clamped rather than wrapped
    assign offsetTooBig  = cfgOffset > OFFSET_W'(OFFSET_MAX_CYC);
    assign offsetClamped = offsetTooBig ? OFFSET_W'(OFFSET_MAX_CYC) : cfgOffset;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg    <= MODE_PPS_GATE;
            ledMask_reg <= `LFC_LEDMASK_RESET;
            offset_reg  <= OFFSET_W'(`LFC_OFFSET_RESET);
            dacCode_reg <= DAC_BITS'(`LFC_DAC_RESET);
        end else if (cfgWrite) begin
            mode_reg    <= cfgMode;
            ledMask_reg <= cfgLedMask;
            offset_reg  <= offsetClamped;
            dacCode_reg <= cfgDacCode;
        end
    end

    // Bias code pushed to the DAC after each settings write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dacLoad_reg <= 1'b0;
        end else begin
            dacLoad_reg <= cfgWrite;
        end
    end

    // ****************************************************************
    // Gate arming
    // ****************************************************************
    logic  armed_reg;
    logic  armed_next;
    logic  gateConsume;
    logic  ppsMode;

    assign ppsMode = (mode_reg == MODE_PPS_GATE) || (mode_reg == MODE_PPS_OFFSET);

    // New arm edge wins over the clear from a firing in the same cycle
    assign armed_next = armRise ? 1'b1
                      : (gateConsume || !armLevel) ? 1'b0
                      : armed_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end

    // ****************************************************************
    // Trigger source decode
    // ****************************************************************
    lfc_state_e state_reg;
    logic       fireGate;
    logic       fireFpga;
    logic       startOffset;
    logic       fireNow;
    logic       idle;

    assign idle        = state_reg == ST_IDLE;
    assign fireGate    = idle && (mode_reg == MODE_PPS_GATE) && armed_reg && ppsRise;
    assign startOffset = idle && (mode_reg == MODE_PPS_OFFSET) && armed_reg && ppsRise;
    assign fireFpga    = idle && (mode_reg == MODE_FPGA) && fpgaRise;
    assign gateConsume = ppsMode && (fireGate || startOffset);
    assign fireNow     = fireGate || fireFpga || (startOffset && offset_reg == '0);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    lfc_state_e           state_next;
    logic [OFFSET_W-1:0]  count_reg;
    logic [OFFSET_W-1:0]  count_next;
    logic [1:0]           fireMask_reg;
    logic [1:0]           fireMask_next;
    logic                 countDone;

    assign countDone = count_reg == '0;

    // Triggers arriving during a delay or pulse are dropped
    always_comb begin
        state_next    = state_reg;
        count_next    = count_reg;
        fireMask_next = fireMask_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fireNow) begin
                    state_next    = ST_PULSE;
                    count_next    = OFFSET_W'(PULSE_CYC - 1);
                    fireMask_next = ledMask_reg;
                end else if (startOffset) begin
                    state_next    = ST_DELAY;
                    count_next    = offset_reg - OFFSET_W'(1);
                    fireMask_next = ledMask_reg;
                end
            end
            ST_DELAY: begin
                if (countDone) begin
                    state_next = ST_PULSE;
                    count_next = OFFSET_W'(PULSE_CYC - 1);
                end else begin
                    count_next = count_reg - OFFSET_W'(1);
                end
            end
            ST_PULSE: begin
                if (countDone) begin
                    state_next = ST_IDLE;
                end else begin
                    count_next = count_reg - OFFSET_W'(1);
                end
            end
            default: begin
                state_next = ST_IDLE;
                count_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            count_reg    <= '0;
            fireMask_reg <= 2'h0;
        end else begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            fireMask_reg <= fireMask_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic [1:0] ledTrigger_reg;
    logic       triggerFlag_reg;
    logic       pulseNext;

    assign pulseNext = state_next == ST_PULSE;

    // Registered so both LEDs switch on the same edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ledTrigger_reg  <= 2'h0;
            triggerFlag_reg <= 1'b0;
        end else begin
            ledTrigger_reg  <= pulseNext ? fireMask_next : 2'h0;
            triggerFlag_reg <= pulseNext && (fireMask_next != 2'h0);
        end
    end

    assign ledTrigger  = ledTrigger_reg;
    assign triggerFlag = triggerFlag_reg;
    assign dacCode     = dacCode_reg;
    assign dacLoad     = dacLoad_reg;
    assign gateArmed   = armed_reg;
    assign modeActive  = mode_reg;

endmodule

// ==== lfc_regs.svh ====
// Purpose: Timing counts and reset values for the LED flash trigger controller
// Assumes: 250 MHz system clock
// Notes:   Definitions only
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define LFC_CLK_PERIOD_NS      4
// Longest offset from the pulse-per-second edge
`define LFC_OFFSET_MAX_NS      1000000
`define LFC_OFFSET_MAX_CYC     (`LFC_OFFSET_MAX_NS / `LFC_CLK_PERIOD_NS)
`define LFC_OFFSET_W           18
// Width of one LED trigger pulse, a least time, so rounded up
`define LFC_PULSE_NS           100
`define LFC_PULSE_CYC          ((`LFC_PULSE_NS + `LFC_CLK_PERIOD_NS - 1) / `LFC_CLK_PERIOD_NS)
`define LFC_DAC_BITS           10

// ****************************************************************
// Reset values of the settings
// ****************************************************************
`define LFC_LEDMASK_RESET      2'h3
`define LFC_OFFSET_RESET       18'h0_0000
`define LFC_DAC_RESET          16'h0000

`endif

// ==== lfc_pkg.sv ====
// Purpose: Types shared by the LED flash trigger controller
// Assumes: Nothing
// Notes:   Timing and reset constants live in lfc_regs.svh
package lfc_pkg;

    // ****************************************************************
    // Trigger source selection
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_PPS_GATE   = 2'h0,
        MODE_FPGA       = 2'h1,
        MODE_PPS_OFFSET = 2'h2,
        MODE_OFF        = 2'h3
    } lfc_mode_e;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DELAY = 3'h2,
        ST_PULSE = 3'h4
    } lfc_state_e;

endpackage

// ==== lfc_sync_edge.sv ====
// Purpose: Two-flop synchroniser with rising-edge detect
// Assumes: Input is asynchronous to clk
// Notes:   Edge is seen two clocks after the pin settles
`timescale 1ns/1ns
module lfc_sync_edge (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncLevel,
    output logic      riseEdge
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // First flop is read by the second only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= asyncIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign syncLevel = sync_reg;
    assign riseEdge  = sync_reg & ~prev_reg;

endmodule

// ==== lfc_props.sv ====
// Purpose: Port assertions for the LED flash trigger
// Assumes: Settings held steady around a flash
// Notes:   Bound to the top module below
`timescale 1ns/1ns
module lfc_props
    import lfc_pkg::*;
#(
    parameter int unsigned DAC_BITS  = 10,
    parameter int unsigned PULSE_CYC = 25
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                ppsIn,
    input wire logic                fpgaDelayedTrigger,
    input wire logic                cfgWrite,
    input wire lfc_mode_e           cfgMode,
    input wire logic [DAC_BITS-1:0] cfgDacCode,
    input wire logic [1:0]          ledTrigger,
    input wire logic                triggerFlag,
    input wire logic [DAC_BITS-1:0] dacCode,
    input wire logic                dacLoad,
    input wire logic                gateArmed,
    input wire lfc_mode_e           modeActive
);
    // ****
    // Checks
    // ****
    // Width is a parameter, so counted rather than repeated
    logic [7:0] onCnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            onCnt <= 8'h00;
        else
            onCnt <= triggerFlag ? onCnt + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    flag_follows_led_a: assert property (triggerFlag == (|ledTrigger))
        else $error("flag differs from LED outputs");
    dac_load_pulse_a: assert property (dacLoad == $past(cfgWrite))
        else $error("load pulse out of step with write");
    dac_code_take_a: assert property (cfgWrite |=> dacCode == $past(cfgDacCode))
        else $error("bias code not taken");
    dac_code_hold_a: assert property (!cfgWrite |=> $stable(dacCode))
        else $error("bias code moved without write");
    mode_take_a: assert property (cfgWrite |=> modeActive == $past(cfgMode))
        else $error("mode not taken");
    pulse_width_a: assert property ($fell(triggerFlag) |-> onCnt == PULSE_CYC)
        else $error("flash width wrong");
    gate_latency_a: assert property ($rose(triggerFlag) && modeActive == MODE_PPS_GATE
        |-> $past(ppsIn, 3) && !$past(ppsIn, 4)) else $error("gated flash off its edge");
    fpga_latency_a: assert property ($rose(triggerFlag) && modeActive == MODE_FPGA
        |-> $past(fpgaDelayedTrigger, 3) && !$past(fpgaDelayedTrigger, 4))
        else $error("fpga flash off its edge");
    gate_consumed_a: assert property ($rose(triggerFlag) && modeActive == MODE_PPS_GATE
        |-> $past(gateArmed) && !gateArmed) else $error("gate not armed or not consumed");
    mode_off_quiet_a: assert property (modeActive == MODE_OFF |-> !$rose(triggerFlag))
        else $error("flash while off");
endmodule
bind lfc_led_flash_trigger lfc_props #(.DAC_BITS(DAC_BITS), .PULSE_CYC(PULSE_CYC)) props (
    .clk(clk), .rst_n(rst_n), .ppsIn(ppsIn), .fpgaDelayedTrigger(fpgaDelayedTrigger),
    .cfgWrite(cfgWrite), .cfgMode(cfgMode), .cfgDacCode(cfgDacCode),
    .ledTrigger(ledTrigger), .triggerFlag(triggerFlag), .dacCode(dacCode),
    .dacLoad(dacLoad), .gateArmed(gateArmed), .modeActive(modeActive));

// ==== lfc_far_model.sv ====
// Purpose: GPS pulse and FPGA delayed trigger source
// Assumes: go is a one-cycle request from the bench
// Notes:   Both lines drop low after five cycles
`timescale 1ns/1ns
module lfc_far_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       fpgaEn,
    input  wire logic [7:0] fpgaDly,
    output logic            ppsIn = 1'b0,
    output logic            fpgaDelayedTrigger = 1'b0
);
    logic [7:0] tick = 8'hff;
    always @(posedge clk) begin
        if (go)
            tick <= 8'h00;
        else if (tick != 8'hff)
            tick <= tick + 8'h01;
    end
    // Falling edge keeps pins clear of the sampling edge
    always @(negedge clk) begin
        ppsIn <= tick < 8'h05;
        fpgaDelayedTrigger <= fpgaEn && tick >= fpgaDly && tick < fpgaDly + 8'h05;
    end
endmodule

// ==== lfc_led_flash_trigger_bench.sv ====
// Purpose: Self-checking bench for the LED flash trigger
// Assumes: Short offset and pulse counts
// Notes:   Latency counted in falling edges from request
`timescale 1ns/1ns
module lfc_led_flash_trigger_bench;
    import lfc_pkg::*;
    logic            clk        = 1'b0;
    logic            rst_n      = 1'b0;
    logic            go         = 1'b0;
    logic            fpgaEn     = 1'b0;
    logic            ppsGateArm = 1'b0;
    logic            cfgWrite   = 1'b0;
    logic [7:0]      fpgaDly    = 8'h00;
    lfc_mode_e       cfgMode    = MODE_OFF;
    logic [1:0]      cfgLedMask = 2'h0;
    logic [17:0]     cfgOffset  = 18'h0_0000;
    logic [9:0]      cfgDacCode = 10'h000;
    wire logic       ppsIn, fpgaDelayedTrigger, triggerFlag, dacLoad, gateArmed;
    wire logic [1:0] ledTrigger;
    wire logic [9:0] dacCode;
    wire lfc_mode_e  modeActive;
    int              fails      = 0;
    int              checkCount = 0;
    lfc_far_model far (.clk(clk), .go(go), .fpgaEn(fpgaEn), .fpgaDly(fpgaDly), .ppsIn(ppsIn),
        .fpgaDelayedTrigger(fpgaDelayedTrigger));
    lfc_led_flash_trigger #(.OFFSET_MAX_CYC(50), .PULSE_CYC(3)) dut (.clk(clk), .rst_n(rst_n),
        .ppsIn(ppsIn), .ppsGateArm(ppsGateArm), .fpgaDelayedTrigger(fpgaDelayedTrigger),
        .cfgWrite(cfgWrite), .cfgMode(cfgMode), .cfgLedMask(cfgLedMask), .cfgOffset(cfgOffset),
        .cfgDacCode(cfgDacCode), .ledTrigger(ledTrigger), .triggerFlag(triggerFlag),
        .dacCode(dacCode), .dacLoad(dacLoad), .gateArmed(gateArmed), .modeActive(modeActive));
    initial begin
        forever #2 clk = ~clk;
    end
    // ****
    // Tasks
    // ****
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cfg(input lfc_mode_e m, input logic [1:0] mk, input logic [17:0] off,
                       input logic [9:0] dac);
        @(negedge clk);
        cfgMode = m;
        cfgLedMask = mk;
        cfgOffset = off;
        cfgDacCode = dac;
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        check("dacLoad", 1, dacLoad);
        check("dacCode", dac, dacCode);
        check("mode", m, modeActive);
        @(negedge clk);
        check("dacLoad end", 0, dacLoad);
    endtask
    // No flash expected is given as latency 80, the wait limit
    task automatic flash(input logic arm, input logic fe, input logic [7:0] dl,
                         input logic [1:0] expLed, input int lat);
        int n;
        ppsGateArm = 1'b0;
        fpgaEn = fe;
        fpgaDly = dl;
        repeat (4) @(negedge clk);
        ppsGateArm = arm;
        repeat (5) @(negedge clk);
        check("armed", arm, gateArmed);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        n = 1;
        while (triggerFlag !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        check("latency", lat, n);
        check("led", expLed, ledTrigger);
        n = 0;
        while (triggerFlag === 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        if (lat < 80) check("width", 3, n);
        repeat (20) @(negedge clk);
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        #40000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check("rst led", 0, ledTrigger);
        check("rst dac", 0, dacCode);
        check("rst mode", MODE_PPS_GATE, modeActive);
        check("rst arm", 0, gateArmed);
        // Request to flag is four falling edges: pin drive, two sync flops, output flop
        cfg(MODE_PPS_GATE, 2'h1, 18'h0_0000, 10'h03ff);
        flash(1, 0, 0, 2'h1, 4);
        flash(0, 1, 0, 2'h0, 80);
        cfg(MODE_PPS_GATE, 2'h2, 18'h0_0000, 10'h0155);
        flash(1, 0, 0, 2'h2, 4);
        cfg(MODE_PPS_GATE, 2'h3, 18'h0_0009, 10'h02aa);
        flash(1, 0, 0, 2'h3, 4);
        cfg(MODE_PPS_GATE, 2'h0, 18'h0_0000, 10'h0001);
        flash(1, 0, 0, 2'h0, 80);
        cfg(MODE_PPS_OFFSET, 2'h3, 18'h0_0007, 10'h0000);
        flash(1, 0, 0, 2'h3, 11);
        cfg(MODE_PPS_OFFSET, 2'h1, 18'h0_003c, 10'h0000);
        flash(1, 0, 0, 2'h1, 54);
        cfg(MODE_FPGA, 2'h3, 18'h0_0000, 10'h0000);
        flash(0, 1, 0, 2'h3, 4);
        flash(0, 1, 9, 2'h3, 13);
        flash(1, 0, 0, 2'h0, 80);
        cfg(MODE_OFF, 2'h3, 18'h0_0000, 10'h0000);
        flash(1, 1, 0, 2'h0, 80);
        give_verdict();
    end
endmodule
